// ### include/pin_mux_pkg.sv
// constants, types and register map of the pin function and mode latch block
// assumes a single 200 MHz clock and an AHB-Lite master with single word transfers
// Function
// - external bus pin roles are fixed at reset and never change afterwards
// - software may switch serial port pin roles at any time without reset
// - shared flag and interrupt pins keep both functions active together
// - four mode pins sampled only around reset, then serve as flag pins
// - four interrupt inputs share the four upper programmable flag pins
// - the two low level interrupt inputs request while held asserted
// - the edge interrupt input requests on its asserting transition only
// - enabled interrupt fires whether pin driven outside or by own flag output
// - system control bit picks serial or alternate role for second serial port pins
// - host mode pin low at reset selects full memory mode
// - latched bus mode stays unchanged while the processor runs
// - full memory mode drives a 14 bit address shared by all spaces
// - 24 bit data bus; byte accesses put upper address on top 8 lines
// - host mode pin high at reset selects host mode with limited addressing
// - external master requests buses, device grants before master drives them
// - three fixed flag pins are always outputs
// - power-down acknowledge asserted once power-down state is entered
package pin_mux_pkg;
  localparam int unsigned ADDR_W    = 14;
  localparam int unsigned DATA_W    = 24;
  localparam int unsigned BYTE_HI_W = 8;
  localparam int unsigned FLAG_W    = 8;
  localparam int unsigned FIXED_W   = 3;
  localparam int unsigned NIRQ      = 8;
  localparam int unsigned CNT_W     = 8;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_MODE     = 8'h04;
  localparam logic [7:0] OFF_FLAG_DIR = 8'h08;
  localparam logic [7:0] OFF_FLAG_OUT = 8'h0c;
  localparam logic [7:0] OFF_FLAG_IN  = 8'h10;
  localparam logic [7:0] OFF_FIXED    = 8'h14;
  localparam logic [7:0] OFF_ICNTL    = 8'h18;
  localparam logic [7:0] OFF_STATUS   = 8'h1c;
  localparam logic [7:0] OFF_MASK     = 8'h20;
  localparam logic [7:0] OFF_EXT_ADDR = 8'h24;
  localparam logic [7:0] OFF_EXT_DATA = 8'h28;
  localparam logic [7:0] OFF_EXT_CMD  = 8'h2c;

  // reset values
  localparam logic [1:0]  CTRL_RST     = 2'h0;
  localparam logic [7:0]  FLAG_DIR_RST = 8'h00;
  localparam logic [7:0]  FLAG_OUT_RST = 8'hff;
  localparam logic [2:0]  FIXED_RST    = 3'h0;
  localparam logic [2:0]  ICNTL_RST    = 3'h0;
  localparam logic [7:0]  MASK_RST     = 8'h00;
  localparam logic [6:0]  STRB_IDLE    = 7'h7f;

  // flag pin positions of shared functions
  localparam int unsigned PF_EDGE_OR_LEVEL = 7;
  localparam int unsigned PF_LEVEL_B       = 6;
  localparam int unsigned PF_LEVEL_A       = 5;
  localparam int unsigned PF_EDGE          = 4;
  localparam int unsigned PF_HOST_MODE     = 2;

  // status and mask bit positions
  localparam int unsigned IRQ_EDGE_OR_LEVEL = 0;
  localparam int unsigned IRQ_LEVEL_B       = 1;
  localparam int unsigned IRQ_LEVEL_A       = 2;
  localparam int unsigned IRQ_EDGE          = 3;
  localparam int unsigned IRQ_ALT1          = 4;
  localparam int unsigned IRQ_ALT0          = 5;
  localparam int unsigned IRQ_PWRDN         = 6;
  localparam int unsigned IRQ_EXT_DONE      = 7;

  // space codes double as strobe indices; read and write strobes follow
  localparam logic [2:0] SPACE_DATA     = 3'h0;
  localparam logic [2:0] SPACE_PROGRAM  = 3'h1;
  localparam logic [2:0] SPACE_IO       = 3'h2;
  localparam logic [2:0] SPACE_BYTE     = 3'h3;
  localparam logic [2:0] SPACE_COMBINED = 3'h4;
  localparam int unsigned STRB_RD       = 5;
  localparam int unsigned STRB_WR       = 6;

  // timing
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned STROBE_NS     = 15;
  localparam int unsigned STROBE_CYC    =
    (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned MODE_CAP_CYC  = 2;

  typedef enum logic [1:0] {ACC_IDLE, ACC_STROBE, ACC_DONE} acc_state_t;

  typedef struct packed {
    logic pd_force;
    logic alt_serial;
  } ctrl_t;

  typedef struct packed {
    logic       valid;
    logic       host;
    logic [3:0] pins;
  } mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] doe;
    logic [6:0]        strb_n;
  } ext_bus_t;
endpackage : pin_mux_pkg

// ### src/pin_sync.sv
// two flop synchroniser for a vector of pin inputs
// assumes each bit is an independent level; the first stage feeds only the second
`timescale 1ns/10ps
module pin_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // pins in, synchronised levels out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } state_t;

  state_t s_reg;
  state_t s_next;

  always_comb begin
    s_next        = s_reg;
    s_next.meta   = async_in;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.stable;
endmodule : pin_sync

// ### src/irq_latch.sv
// one sticky interrupt status bit with level or edge capture
// assumes req is active high and already in the hclk domain
`timescale 1ns/10ps
module irq_latch (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // request and control
  input  wire logic req,
  input  wire logic edge_mode,
  input  wire logic clear,
  // sticky status
  output logic      status
);
  typedef struct packed {
    logic prev;
    logic stat;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic   set;

  always_comb begin
    s_next = s_reg;
    // a held level sets every cycle so it survives a clear while asserted
    set = edge_mode ? (req & ~s_reg.prev) : req;
    s_next.prev = req;
    // set wins over a simultaneous clear
    s_next.stat = set | (s_reg.stat & ~clear);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign status = s_reg.stat;
endmodule : irq_latch

// ### src/pin_function_mode_latch.sv
// pin function selection, mode latch, flag and interrupt sharing, external bus
// assumes an AHB-Lite master on hclk and pins asynchronous to hclk
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module pin_function_mode_latch #(
  parameter int unsigned STROBE_CYC = pin_mux_pkg::STROBE_CYC
) (
  // clock and reset
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  // ahb-lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic                               irq,
  // programmable flag pins, mode straps and shared interrupts
  input  wire logic [7:0]                    programmable_flag_pins_in,
  output logic      [7:0]                    programmable_flag_pins_out,
  output logic      [7:0]                    programmable_flag_pins_oe,
  output logic      [2:0]                    fixed_output_flags,
  output pin_mux_pkg::mode_t                 mode_latched,
  // second serial port alternate role
  input  wire logic [1:0]                    serial_alt_irq_pins_n,
  input  wire logic                          serial_alt_flag_in,
  output logic                               serial_alt_flag_out,
  output logic                               serial_alt_flag_out_oe,
  output logic                               serial_port_owns_pins,
  // external bus and bus arbitration
  input  wire logic [23:0]                   external_data_bus_in,
  output pin_mux_pkg::ext_bus_t              external_bus,
  input  wire logic                          bus_request_in_n,
  output logic                               bus_grant_out_n,
  output logic                               bus_grant_hung_out_n,
  // power-down
  input  wire logic                          powerdown_request_in_n,
  output logic                               powerdown_ack_out
);
  localparam int unsigned SYNC_W = 37;

  typedef struct packed {
    logic [31:0]               hrdata;
    logic                      hready;
    logic                      hresp;
    logic                      rd_pend;
    logic                      wr_pend;
    logic [7:0]                addr_q;
    pin_mux_pkg::ctrl_t        ctrl;
    pin_mux_pkg::mode_t        mode;
    logic [1:0]                cap_cnt;
    logic [7:0]                flag_dir;
    logic [7:0]                flag_out;
    logic [7:0]                pf_oe;
    logic [2:0]                fixed;
    logic                      alt_fo;
    logic                      sp_owns;
    logic [2:0]                icntl;
    logic [7:0]                mask;
    logic                      irq;
    logic [21:0]               ext_addr;
    logic [23:0]               ext_wdata;
    logic [23:0]               ext_rdata;
    logic [2:0]                space;
    logic                      ext_write;
    logic                      pending;
    pin_mux_pkg::acc_state_t   acc;
    logic [7:0]                cnt;
    logic                      grant;
    logic                      hung;
    logic                      pd;
    pin_mux_pkg::ext_bus_t     bus;
  } state_t;

  state_t        s_reg;
  state_t        s_next;
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_q;
  logic [7:0]    pf_sync;
  logic [1:0]    alt_irq_sync_n;
  logic          alt_fi_sync;
  logic          br_sync_n;
  logic          pwd_sync_n;
  logic [23:0]   dbus_sync;
  logic [7:0]    eff_pf;
  logic [7:0]    irq_req;
  logic [7:0]    irq_edge;
  logic [7:0]    irq_clr;
  logic [7:0]    irq_status;
  logic          take;
  logic          space_ok;
  logic          start;
  logic          pd_req;
  logic [31:0]   rd_val;

  assign sync_in = {external_data_bus_in, powerdown_request_in_n, bus_request_in_n,
                    serial_alt_flag_in, serial_alt_irq_pins_n, programmable_flag_pins_in};

  pin_sync #(.W(SYNC_W)) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (sync_in),
    .sync_out (sync_q)
  );

  assign pf_sync        = sync_q[7:0];
  assign alt_irq_sync_n = sync_q[9:8];
  assign alt_fi_sync    = sync_q[10];
  assign br_sync_n      = sync_q[11];
  assign pwd_sync_n     = sync_q[12];
  assign dbus_sync      = sync_q[36:13];

  // an output flag is seen by its interrupt without the pad round trip
  assign eff_pf = (s_reg.flag_dir & s_reg.flag_out) | (~s_reg.flag_dir & pf_sync);

  // upper flag pins double as the four interrupt inputs, all active low
  always_comb begin
    irq_req  = 8'h00;
    irq_edge = 8'h00;
    irq_req[pin_mux_pkg::IRQ_EDGE_OR_LEVEL]  = ~eff_pf[pin_mux_pkg::PF_EDGE_OR_LEVEL];
    irq_edge[pin_mux_pkg::IRQ_EDGE_OR_LEVEL] = s_reg.icntl[0];
    irq_req[pin_mux_pkg::IRQ_LEVEL_B]  = ~eff_pf[pin_mux_pkg::PF_LEVEL_B];
    irq_req[pin_mux_pkg::IRQ_LEVEL_A]  = ~eff_pf[pin_mux_pkg::PF_LEVEL_A];
    irq_req[pin_mux_pkg::IRQ_EDGE]     = ~eff_pf[pin_mux_pkg::PF_EDGE];
    irq_edge[pin_mux_pkg::IRQ_EDGE]    = 1'b1;
    // alternate serial interrupts only count while that role is selected
    irq_req[pin_mux_pkg::IRQ_ALT1]  = s_reg.ctrl.alt_serial & ~alt_irq_sync_n[1];
    irq_edge[pin_mux_pkg::IRQ_ALT1] = s_reg.icntl[1];
    irq_req[pin_mux_pkg::IRQ_ALT0]  = s_reg.ctrl.alt_serial & ~alt_irq_sync_n[0];
    irq_edge[pin_mux_pkg::IRQ_ALT0] = s_reg.icntl[2];
    irq_req[pin_mux_pkg::IRQ_PWRDN]      = s_reg.pd;
    irq_edge[pin_mux_pkg::IRQ_PWRDN]     = 1'b1;
    irq_req[pin_mux_pkg::IRQ_EXT_DONE]   = (s_reg.acc == pin_mux_pkg::ACC_DONE);
    irq_edge[pin_mux_pkg::IRQ_EXT_DONE]  = 1'b1;
    // synchroniser flops reset low, which would read as asserted requests until straps land
    irq_req = irq_req & {8{s_reg.mode.valid}};
  end

  assign irq_clr = (s_reg.wr_pend && s_reg.addr_q == pin_mux_pkg::OFF_STATUS) ?
                   hwdata[7:0] : 8'h00;

  genvar gi;
  generate
    for (gi = 0; gi < pin_mux_pkg::NIRQ; gi++) begin : g_irq
      irq_latch u_irq (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .req       (irq_req[gi]),
        .edge_mode (irq_edge[gi]),
        .clear     (irq_clr[gi]),
        .status    (irq_status[gi])
      );
    end
  endgenerate

  assign take     = hsel & hready & htrans[1];
  assign space_ok = (hwdata[2:0] <= pin_mux_pkg::SPACE_COMBINED);
  assign pd_req   = (~pwd_sync_n | s_reg.ctrl.pd_force) & s_reg.mode.valid;
  assign start    = s_reg.pending & ~s_reg.grant & ~s_reg.pd & s_reg.mode.valid &
                    (s_reg.acc == pin_mux_pkg::ACC_IDLE);

  always_comb begin
    case (s_reg.addr_q)
      pin_mux_pkg::OFF_CTRL:     rd_val = {30'h0, s_reg.ctrl};
      pin_mux_pkg::OFF_MODE:     rd_val = {26'h0, s_reg.mode};
      pin_mux_pkg::OFF_FLAG_DIR: rd_val = {24'h0, s_reg.flag_dir};
      pin_mux_pkg::OFF_FLAG_OUT: rd_val = {24'h0, s_reg.flag_out};
      pin_mux_pkg::OFF_FLAG_IN:  rd_val = {23'h0, alt_fi_sync, pf_sync};
      pin_mux_pkg::OFF_FIXED:    rd_val = {28'h0, s_reg.alt_fo, s_reg.fixed};
      pin_mux_pkg::OFF_ICNTL:    rd_val = {29'h0, s_reg.icntl};
      pin_mux_pkg::OFF_STATUS:   rd_val = {24'h0, irq_status};
      pin_mux_pkg::OFF_MASK:     rd_val = {24'h0, s_reg.mask};
      pin_mux_pkg::OFF_EXT_ADDR: rd_val = {10'h0, s_reg.ext_addr};
      pin_mux_pkg::OFF_EXT_DATA: rd_val = {8'h0, s_reg.ext_rdata};
      pin_mux_pkg::OFF_EXT_CMD:  rd_val = {28'h0, s_reg.pd, s_reg.grant, s_reg.pending,
                                           s_reg.acc != pin_mux_pkg::ACC_IDLE};
      default:                   rd_val = 32'h0;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    // bus slave: writes complete at once, reads take one wait state
    if (s_reg.rd_pend) begin
      s_next.hrdata  = rd_val;
      s_next.hready  = 1'b1;
      s_next.rd_pend = 1'b0;
    end
    s_next.wr_pend = 1'b0;
    if (take) begin
      s_next.addr_q  = haddr[7:0];
      s_next.wr_pend = hwrite;
      s_next.rd_pend = ~hwrite;
      s_next.hready  = hwrite;
    end
    if (s_reg.wr_pend) begin
      case (s_reg.addr_q)
        pin_mux_pkg::OFF_CTRL:     s_next.ctrl = hwdata[1:0];
        pin_mux_pkg::OFF_FLAG_DIR: s_next.flag_dir = hwdata[7:0];
        pin_mux_pkg::OFF_FLAG_OUT: s_next.flag_out = hwdata[7:0];
        pin_mux_pkg::OFF_FIXED: begin
          s_next.fixed  = hwdata[2:0];
          s_next.alt_fo = hwdata[3];
        end
        pin_mux_pkg::OFF_ICNTL:    s_next.icntl = hwdata[2:0];
        pin_mux_pkg::OFF_MASK:     s_next.mask = hwdata[7:0];
        pin_mux_pkg::OFF_EXT_ADDR: s_next.ext_addr = hwdata[21:0];
        pin_mux_pkg::OFF_EXT_DATA: s_next.ext_wdata = hwdata[23:0];
        pin_mux_pkg::OFF_EXT_CMD: begin
          // a command while one is queued or running is dropped
          if (space_ok && !s_reg.pending && s_reg.acc == pin_mux_pkg::ACC_IDLE) begin
            s_next.space     = hwdata[2:0];
            s_next.ext_write = hwdata[3];
            s_next.pending   = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // straps settle through the synchroniser, then are frozen for good
    if (!s_reg.mode.valid) begin
      if (s_reg.cap_cnt == 2'(pin_mux_pkg::MODE_CAP_CYC)) begin
        s_next.mode.pins  = pf_sync[3:0];
        s_next.mode.host  = pf_sync[pin_mux_pkg::PF_HOST_MODE];
        s_next.mode.valid = 1'b1;
      end else begin
        s_next.cap_cnt = s_reg.cap_cnt + 2'h1;
      end
    end

    // pins only turn into driven flags once the straps have been taken
    s_next.pf_oe   = s_reg.flag_dir & {8{s_reg.mode.valid}};
    s_next.sp_owns = ~s_next.ctrl.alt_serial;
    s_next.irq     = |(irq_status & s_reg.mask);

    // power-down waits for any running access to finish
    if (!pd_req) begin
      s_next.pd = 1'b0;
    end else if (s_reg.acc == pin_mux_pkg::ACC_IDLE && !start) begin
      s_next.pd = 1'b1;
    end

    // external master gets the buses only between accesses
    s_next.grant = ~br_sync_n & s_reg.mode.valid &
                   (s_reg.acc == pin_mux_pkg::ACC_IDLE) & ~start;
    s_next.hung  = s_next.grant & s_reg.pending;

    case (s_reg.acc)
      pin_mux_pkg::ACC_IDLE: begin
        if (start) begin
          s_next.pending = 1'b0;
          s_next.acc     = pin_mux_pkg::ACC_STROBE;
          s_next.cnt     = 8'(STROBE_CYC - 1);
          // host mode keeps only the lowest address line
          s_next.bus.addr = s_reg.mode.host ? {13'h0, s_reg.ext_addr[0]} :
                                              s_reg.ext_addr[13:0];
          s_next.bus.dout = s_reg.ext_wdata;
          s_next.bus.doe  = {24{s_reg.ext_write}};
          if (s_reg.space == pin_mux_pkg::SPACE_BYTE) begin
            s_next.bus.dout[23:16] = s_reg.ext_addr[21:14];
            s_next.bus.doe[23:16]  = 8'hff;
          end
          if (s_reg.mode.host) begin
            s_next.bus.doe[7:0] = 8'h00;
          end
          s_next.bus.strb_n = pin_mux_pkg::STRB_IDLE;
          s_next.bus.strb_n[s_reg.space] = 1'b0;
          s_next.bus.strb_n[pin_mux_pkg::STRB_RD] = s_reg.ext_write;
          s_next.bus.strb_n[pin_mux_pkg::STRB_WR] = ~s_reg.ext_write;
        end
      end
      pin_mux_pkg::ACC_STROBE: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.ext_rdata  = dbus_sync;
          s_next.bus.strb_n = pin_mux_pkg::STRB_IDLE;
          s_next.bus.doe    = '0;
          s_next.acc        = pin_mux_pkg::ACC_DONE;
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
      pin_mux_pkg::ACC_DONE: s_next.acc = pin_mux_pkg::ACC_IDLE;
      default:               s_next.acc = pin_mux_pkg::ACC_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg            <= '0;
      s_reg.hready     <= 1'b1;
      s_reg.ctrl       <= pin_mux_pkg::CTRL_RST;
      s_reg.flag_dir   <= pin_mux_pkg::FLAG_DIR_RST;
      s_reg.flag_out   <= pin_mux_pkg::FLAG_OUT_RST;
      s_reg.fixed      <= pin_mux_pkg::FIXED_RST;
      s_reg.icntl      <= pin_mux_pkg::ICNTL_RST;
      s_reg.mask       <= pin_mux_pkg::MASK_RST;
      s_reg.sp_owns    <= 1'b1;
      s_reg.acc        <= pin_mux_pkg::ACC_IDLE;
      s_reg.bus.strb_n <= pin_mux_pkg::STRB_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hrdata                     = s_reg.hrdata;
  assign hreadyout                  = s_reg.hready;
  assign hresp                      = s_reg.hresp;
  assign irq                        = s_reg.irq;
  assign programmable_flag_pins_out = s_reg.flag_out;
  assign programmable_flag_pins_oe  = s_reg.pf_oe;
  assign fixed_output_flags         = s_reg.fixed;
  assign mode_latched               = s_reg.mode;
  assign serial_alt_flag_out        = s_reg.alt_fo;
  assign serial_alt_flag_out_oe     = s_reg.ctrl.alt_serial;
  assign serial_port_owns_pins      = s_reg.sp_owns;
  assign external_bus               = s_reg.bus;
  assign bus_grant_out_n            = ~s_reg.grant;
  assign bus_grant_hung_out_n       = ~s_reg.hung;
  assign powerdown_ack_out          = s_reg.pd;
endmodule : pin_function_mode_latch

// ### verif/pin_mux_sva.sv
// port-level checker of the pin function and mode latch block
// assumes it is bound into the block's top module with default STROBE_CYC of 3
`timescale 1ns/10ps
module pin_mux_sva (
  // clock and reset
  input wire logic                  hclk,
  input wire logic                  hresetn,
  // pins and mode
  input wire logic [7:0]            programmable_flag_pins_in,
  input wire logic [7:0]            programmable_flag_pins_oe,
  input wire pin_mux_pkg::mode_t    mode_latched,
  input wire logic                  serial_alt_flag_out_oe,
  input wire logic                  serial_port_owns_pins,
  // external bus, grant and power-down
  input wire pin_mux_pkg::ext_bus_t external_bus,
  input wire logic                  bus_request_in_n,
  input wire logic                  bus_grant_out_n,
  input wire logic                  powerdown_ack_out
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic [6:0] s = external_bus.strb_n;
  mode_hold_a: assert property (mode_latched.valid |=> $stable(mode_latched))
    else $error("mode changed after capture");
  mode_cap_a: assert property ($rose(mode_latched.valid) |->
    mode_latched.pins == $past(programmable_flag_pins_in[3:0], 3)
    && mode_latched.host == mode_latched.pins[2]) else $error("mode strap mismatch");
  one_select_a: assert property (!(&s[4:0]) |-> $onehot(~s[4:0]) && s[5] != s[6])
    else $error("select or direction strobe wrong");
  strobe_len_a: assert property ($fell(&s[4:0]) |-> (!(&s[4:0]))[*3] ##1 (&s[4:0]))
    else $error("strobe length wrong");
  grant_idle_a: assert property (!bus_grant_out_n |-> &s[4:0])
    else $error("grant during own access");
  grant_cause_a: assert property ($fell(bus_grant_out_n) |-> $past(!bus_request_in_n, 3))
    else $error("grant without request");
  pd_quiet_a: assert property (powerdown_ack_out |-> &s[4:0])
    else $error("access during power-down");
  alt_owner_a: assert property (serial_alt_flag_out_oe == !serial_port_owns_pins)
    else $error("alt flag drive disagrees with owner");
  flag_float_a: assert property (!mode_latched.valid |-> programmable_flag_pins_oe == 8'h00)
    else $error("flag driven before mode capture");
  host_addr_a: assert property (mode_latched.host && !(&s[4:0]) |->
    external_bus.addr[13:1] == 13'h0) else $error("host mode address too wide");
endmodule : pin_mux_sva
bind pin_function_mode_latch pin_mux_sva i_pin_mux_sva (.*);

// ### verif/ext_mem_model.sv
// external memory and bus master on the block's far side
// assumes active low strobes; read data stands for the whole read strobe
`timescale 1ns/10ps
module ext_mem_model (
  // clock and bus from the block
  input  wire logic                  hclk,
  input  wire pin_mux_pkg::ext_bus_t external_bus,
  input  wire logic                  want_bus,
  // answers
  output logic      [23:0]           external_data_bus_in,
  output logic                       bus_request_in_n
);
  logic [23:0] last = 24'h0;
  // released bus shows the inverse, so a late sample never looks right
  assign external_data_bus_in = !external_bus.strb_n[5] ?
    ({10'h0, external_bus.addr} ^ 24'ha5c3f0) : ~last;
  // never drives the shared bus itself, only asks for it
  assign bus_request_in_n = !want_bus;
  always @(posedge hclk) if (!external_bus.strb_n[5]) last <= external_data_bus_in;
endmodule : ext_mem_model

// ### verif/tb_pin_function_mode_latch.sv
// self-checking bench of the pin function and mode latch block
// assumes checker and memory model are compiled before it
`timescale 1ns/10ps
module tb_pin_function_mode_latch;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, want = 1'b0;
  logic [1:0]  htrans = 2'h0, alt_n = 2'h3;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, a;
  logic [7:0]  pf_drv, pf_out, pf_oe;
  logic [5:0]  exp_mode;
  logic [23:0] din;
  logic        hreadyout, breq_n, irq, owns, alt_oe, gnt_n, ack, fo, hung_n;
  logic [2:0]  fx;
  pin_mux_pkg::mode_t    md;
  pin_mux_pkg::ext_bus_t eb;
  int          n_fail = 0, cmp_count = 0, cyc = 0, seed = 53;
  // pad level: whoever enables drives
  wire logic [7:0] pf_pad = (pf_oe & pf_out) | (~pf_oe & pf_drv);
  pin_function_mode_latch i_pin_function_mode_latch (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .irq(irq), .programmable_flag_pins_in(pf_pad), .programmable_flag_pins_out(pf_out),
    .programmable_flag_pins_oe(pf_oe), .fixed_output_flags(fx), .mode_latched(md),
    .serial_alt_irq_pins_n(alt_n), .serial_alt_flag_in(pf_drv[0]),
    .serial_alt_flag_out(fo), .serial_alt_flag_out_oe(alt_oe), .serial_port_owns_pins(owns),
    .external_data_bus_in(din), .external_bus(eb), .bus_request_in_n(breq_n),
    .bus_grant_out_n(gnt_n), .bus_grant_hung_out_n(hung_n), .powerdown_request_in_n(1'b1),
    .powerdown_ack_out(ack));
  ext_mem_model i_ext_mem_model (.hclk(hclk), .external_bus(eb), .want_bus(want),
    .external_data_bus_in(din), .bus_request_in_n(breq_n));
  always #2.5 hclk = ~hclk;
  // whole run needs a few hundred cycles
  always @(posedge hclk) if (++cyc == 20000) begin
    n_fail++;
    test_done();
  end
  function automatic logic [23:0] mem_of(input logic [13:0] ad);
    return {10'h0, ad} ^ 24'ha5c3f0;
  endfunction : mem_of
  task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    htrans <= 2'h2;
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {24'h0, ad};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    ahb(1'b0, ad, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask : wt
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  initial begin
    pf_drv = {4'hf, 4'($random(seed))};
    exp_mode = {1'b1, pf_drv[2], pf_drv[3:0]};
    wt(8);
    hresetn <= 1'b1;
    wt(6);
    rd(8'h04, {26'h0, exp_mode});
    chk({30'h0, owns, alt_oe}, 32'h2);
    pf_drv[3:0] <= ~pf_drv[3:0];
    wt(4);
    rd(8'h04, {26'h0, exp_mode});
    $display("mode test done");
    alt_n <= 2'h2;
    wt(6);
    rd(8'h1c, 32'h0);
    ahb(1'b1, 8'h00, 32'h1);
    wt(6);
    chk({30'h0, owns, alt_oe}, 32'h1);
    rd(8'h1c, 32'h20);
    alt_n <= 2'h3;
    wt(5);
    ahb(1'b1, 8'h00, 32'h0);
    ahb(1'b1, 8'h1c, 32'hff);
    ahb(1'b1, 8'h14, 32'hd);
    wt(2);
    chk({28'h0, fo, fx}, 32'hd);
    $display("serial alt test done");
    ahb(1'b1, 8'h20, 32'h0c);
    pf_drv[5:4] <= 2'h0;
    wt(6);
    ahb(1'b1, 8'h1c, 32'hff);
    wt(2);
    rd(8'h1c, 32'h04);
    chk({31'h0, irq}, 32'h1);
    pf_drv[5] <= 1'b1;
    wt(5);
    ahb(1'b1, 8'h1c, 32'hff);
    ahb(1'b1, 8'h08, 32'h80);
    ahb(1'b1, 8'h0c, 32'h7f);
    wt(4);
    rd(8'h1c, 32'h01);
    chk({31'h0, irq}, 32'h0);
    rd(8'h10, {23'h0, pf_drv[0], 1'b0, pf_drv[6:0]});
    ahb(1'b1, 8'h08, 32'h0);
    ahb(1'b1, 8'h0c, 32'hff);
    pf_drv[4] <= 1'b1;
    wt(5);
    ahb(1'b1, 8'h1c, 32'hff);
    rd(8'h30, 32'h0);
    $display("interrupt test done");
    for (int sp = 0; sp < 5; sp++) begin
      a = {10'h0, 22'($random(seed))};
      ahb(1'b1, 8'h24, a);
      ahb(1'b1, 8'h2c, sp);
      do ahb(1'b0, 8'h2c, 32'h0); while (q[1:0] !== 2'h0);
      rd(8'h28, {8'h0, mem_of(md.host ? {13'h0, a[0]} : a[13:0])});
      chk(eb.addr, md.host ? {13'h0, a[0]} : a[13:0]);
      if (sp == 3) chk(eb.dout[23:16], a[21:14]);
    end
    ahb(1'b1, 8'h28, 32'h5a5a5a);
    ahb(1'b1, 8'h2c, 32'h8);
    do ahb(1'b0, 8'h2c, 32'h0); while (q[1:0] !== 2'h0);
    chk(eb.dout, 24'h5a5a5a);
    $display("external access test done");
    want <= 1'b1;
    wt(6);
    chk({31'h0, gnt_n}, 32'h0);
    ahb(1'b1, 8'h2c, 32'h0);
    wt(4);
    chk({31'h0, hung_n}, 32'h0);
    want <= 1'b0;
    wt(6);
    chk({31'h0, gnt_n}, 32'h1);
    ahb(1'b1, 8'h00, 32'h2);
    wt(4);
    chk({31'h0, ack}, 32'h1);
    ahb(1'b1, 8'h00, 32'h0);
    wt(4);
    chk({31'h0, ack}, 32'h0);
    $display("grant and power-down test done");
    test_done();
  end
endmodule : tb_pin_function_mode_latch
